// ==== a8tc_pkg.sv ====
// Constants and types of the 8-bit asynchronous timer with one compare channel
package a8tc_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [2:0] A8TC_OFS_CTRL = 3'h0;
   localparam logic [2:0] A8TC_OFS_COUNT = 3'h1;
   localparam logic [2:0] A8TC_OFS_COMPARE = 3'h2;
   localparam logic [2:0] A8TC_OFS_FLAG = 3'h3;
   localparam logic [2:0] A8TC_OFS_MASK = 3'h4;
   localparam logic [2:0] A8TC_OFS_ASYNC = 3'h5;

   // ****************************************
   // Control register fields
   // ****************************************
   localparam int A8TC_CS_LSB = 0;
   localparam int A8TC_WGM_LSB = 3;
   localparam int A8TC_COM_LSB = 5;
   localparam int A8TC_FOC_BIT = 7;

   // ****************************************
   // Flag, mask and async status bits
   // ****************************************
   localparam int A8TC_OVF_BIT = 0;
   localparam int A8TC_CMP_BIT = 1;
   localparam int A8TC_ASO_BIT = 3;

   // ****************************************
   // Count limits and reset values
   // ****************************************
   localparam logic [7:0] A8TC_BOTTOM = 8'h00;
   localparam logic [7:0] A8TC_MAX = 8'hff;
   localparam logic [7:0] A8TC_RST_BYTE = 8'h00;
   localparam logic [9:0] A8TC_RST_PRESCALE = 10'h000;

   // ****************************************
   // Waveform modes
   // ****************************************
   localparam logic [1:0] A8TC_WGM_NORMAL = 2'h0;
   localparam logic [1:0] A8TC_WGM_PHASE = 2'h1;
   localparam logic [1:0] A8TC_WGM_CTC = 2'h2;
   localparam logic [1:0] A8TC_WGM_FAST = 2'h3;

   // ****************************************
   // Compare output actions
   // ****************************************
   localparam logic [1:0] A8TC_COM_NONE = 2'h0;
   localparam logic [1:0] A8TC_COM_TOGGLE = 2'h1;
   localparam logic [1:0] A8TC_COM_CLEAR = 2'h2;
   localparam logic [1:0] A8TC_COM_SET = 2'h3;

   // ****************************************
   // Counter direction state
   // ****************************************
   typedef enum logic [1:0] {
      A8TC_DIR_UP = 2'b01,
      A8TC_DIR_DOWN = 2'b10
   } a8tc_dir_e;
endpackage

// ==== a8tc_timer.sv ====
// 8-bit up/down timer with clock select, one compare channel and register port
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module a8tc_timer (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic crystal_pin_in_i,
   output logic crystal_pin_out_o,
   input wire logic ovf_irq_ack_i,
   input wire logic cmp_irq_ack_i,
   output logic ovf_irq_o,
   output logic cmp_irq_o,
   output logic compare_output_o
);

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic tap_hit(input logic [9:0] pre, input logic [2:0] cs);
      logic hit;
      hit = 1'b0;
      case (cs)
         3'h1: hit = 1'b1;
         3'h2: hit = &pre[2:0];
         3'h3: hit = &pre[4:0];
         3'h4: hit = &pre[5:0];
         3'h5: hit = &pre[6:0];
         3'h6: hit = &pre[7:0];
         3'h7: hit = &pre[9:0];
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   function automatic logic com_level(input logic [1:0] com, input logic cur);
      logic lvl;
      lvl = cur;
      case (com)
         a8tc_pkg::A8TC_COM_TOGGLE: lvl = ~cur;
         a8tc_pkg::A8TC_COM_CLEAR: lvl = 1'b0;
         a8tc_pkg::A8TC_COM_SET: lvl = 1'b1;
         default: lvl = cur;
      endcase
      return lvl;
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [2:0] cs_reg;
   logic [1:0] wgm_reg;
   logic [1:0] com_reg;
   logic aso_reg;
   logic [7:0] count_value_reg;
   logic [7:0] count_value_next;
   logic [7:0] compare_value_reg;
   logic [7:0] compare_value_next;
   logic [7:0] compare_buffer_reg;
   logic ovf_flag_reg;
   logic cmp_flag_reg;
   logic ovf_mask_reg;
   logic cmp_mask_reg;
   logic block_reg;
   logic out_reg;
   logic out_next;
   logic [9:0] prescale_reg;
   logic osc_meta_reg;
   logic osc_sync_reg;
   logic osc_prev_reg;
   a8tc_pkg::a8tc_dir_e dir_reg;
   a8tc_pkg::a8tc_dir_e dir_next;

   // ****************************************
   // Decode
   // ****************************************
   wire logic wr_ctrl = wr_i && (addr_i == a8tc_pkg::A8TC_OFS_CTRL);
   wire logic wr_count = wr_i && (addr_i == a8tc_pkg::A8TC_OFS_COUNT);
   wire logic wr_compare = wr_i && (addr_i == a8tc_pkg::A8TC_OFS_COMPARE);
   wire logic wr_flag = wr_i && (addr_i == a8tc_pkg::A8TC_OFS_FLAG);
   wire logic wr_mask = wr_i && (addr_i == a8tc_pkg::A8TC_OFS_MASK);
   wire logic wr_async = wr_i && (addr_i == a8tc_pkg::A8TC_OFS_ASYNC);

   wire logic pwm_mode = (wgm_reg == a8tc_pkg::A8TC_WGM_PHASE) ||
      (wgm_reg == a8tc_pkg::A8TC_WGM_FAST);
   wire logic force_strobe = wr_ctrl && wdata_i[a8tc_pkg::A8TC_FOC_BIT] && !pwm_mode;

   // ****************************************
   // Tick generation
   // ****************************************
   wire logic osc_rise = osc_sync_reg && !osc_prev_reg;
   wire logic src_pulse = aso_reg ? osc_rise : 1'b1;
   wire logic stopped = (cs_reg == 3'h0);
   wire logic tick = src_pulse && !stopped && tap_hit(prescale_reg, cs_reg);

   // ****************************************
   // Count limits and compare
   // ****************************************
   wire logic at_bottom = (count_value_reg == a8tc_pkg::A8TC_BOTTOM);
   wire logic at_max = (count_value_reg == a8tc_pkg::A8TC_MAX);
   wire logic match = (count_value_reg == compare_value_reg);
   wire logic ctc_mode = (wgm_reg == a8tc_pkg::A8TC_WGM_CTC);
   wire logic at_top = ctc_mode ? match : at_max;
   wire logic tick_match = tick && match && !block_reg;

   // ****************************************
   // Next count, direction and overflow
   // ****************************************
   logic ovf_event;
   always_comb begin
      count_value_next = count_value_reg;
      dir_next = dir_reg;
      ovf_event = 1'b0;
      case (wgm_reg)
         a8tc_pkg::A8TC_WGM_NORMAL: begin
            count_value_next = count_value_reg + 8'h01;
            ovf_event = at_max;
         end
         a8tc_pkg::A8TC_WGM_CTC: begin
            if (tick_match) begin
               count_value_next = a8tc_pkg::A8TC_BOTTOM;
            end else begin
               count_value_next = count_value_reg + 8'h01;
            end
            ovf_event = at_max && !tick_match;
         end
         a8tc_pkg::A8TC_WGM_FAST: begin
            if (at_top) begin
               count_value_next = a8tc_pkg::A8TC_BOTTOM;
            end else begin
               count_value_next = count_value_reg + 8'h01;
            end
            ovf_event = at_max;
         end
         default: begin
            if (dir_reg == a8tc_pkg::A8TC_DIR_UP) begin
               if (at_max) begin
                  dir_next = a8tc_pkg::A8TC_DIR_DOWN;
                  count_value_next = count_value_reg - 8'h01;
               end else begin
                  count_value_next = count_value_reg + 8'h01;
               end
            end else begin
               if (at_bottom) begin
                  dir_next = a8tc_pkg::A8TC_DIR_UP;
                  count_value_next = count_value_reg + 8'h01;
               end else begin
                  count_value_next = count_value_reg - 8'h01;
               end
            end
            ovf_event = at_bottom && (dir_reg == a8tc_pkg::A8TC_DIR_DOWN);
         end
      endcase
   end

   // ****************************************
   // Compare value and buffer
   // ****************************************
   wire logic buf_load = pwm_mode && tick &&
      ((wgm_reg == a8tc_pkg::A8TC_WGM_FAST) ? at_max :
      (at_max && dir_reg == a8tc_pkg::A8TC_DIR_UP));

   always_comb begin
      compare_value_next = compare_value_reg;
      if (wr_compare && !pwm_mode) begin
         compare_value_next = wdata_i;
      end else if (buf_load) begin
         compare_value_next = compare_buffer_reg;
      end
   end

   // ****************************************
   // Compare output next level
   // ****************************************
   always_comb begin
      out_next = out_reg;
      if (force_strobe) begin
         out_next = com_level(com_reg, out_reg);
      end else if (tick) begin
         if (!pwm_mode) begin
            if (tick_match) begin
               out_next = com_level(com_reg, out_reg);
            end
         end else if (wgm_reg == a8tc_pkg::A8TC_WGM_FAST) begin
            if (tick_match && com_reg[1]) begin
               out_next = com_reg[0];
            end else if (at_max && com_reg[1]) begin
               out_next = ~com_reg[0];
            end
         end else begin
            if (tick_match && com_reg[1]) begin
               out_next = (dir_reg == a8tc_pkg::A8TC_DIR_UP) ? com_reg[0] : ~com_reg[0];
            end
         end
      end
   end

   // ****************************************
   // Read mux
   // ****************************************
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (addr_i == a8tc_pkg::A8TC_OFS_CTRL) begin
         rd_mux = {1'b0, com_reg, wgm_reg, cs_reg};
      end else if (addr_i == a8tc_pkg::A8TC_OFS_COUNT) begin
         rd_mux = count_value_reg;
      end else if (addr_i == a8tc_pkg::A8TC_OFS_COMPARE) begin
         rd_mux = pwm_mode ? compare_buffer_reg : compare_value_reg;
      end else if (addr_i == a8tc_pkg::A8TC_OFS_FLAG) begin
         rd_mux = {6'h00, cmp_flag_reg, ovf_flag_reg};
      end else if (addr_i == a8tc_pkg::A8TC_OFS_MASK) begin
         rd_mux = {6'h00, cmp_mask_reg, ovf_mask_reg};
      end else if (addr_i == a8tc_pkg::A8TC_OFS_ASYNC) begin
         rd_mux = {4'h0, aso_reg, 3'h0};
      end
   end

   // ****************************************
   // Oscillator synchroniser
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
      end else begin
         osc_meta_reg <= crystal_pin_in_i;
         osc_sync_reg <= osc_meta_reg;
         osc_prev_reg <= osc_sync_reg;
      end
   end

   // ****************************************
   // Prescaler
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prescale_reg <= a8tc_pkg::A8TC_RST_PRESCALE;
      end else if (stopped) begin
         prescale_reg <= a8tc_pkg::A8TC_RST_PRESCALE;
      end else if (src_pulse) begin
         prescale_reg <= prescale_reg + 10'h001;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_reg <= 3'h0;
         wgm_reg <= a8tc_pkg::A8TC_WGM_NORMAL;
         com_reg <= a8tc_pkg::A8TC_COM_NONE;
         aso_reg <= 1'b0;
         ovf_mask_reg <= 1'b0;
         cmp_mask_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            cs_reg <= wdata_i[a8tc_pkg::A8TC_CS_LSB +: 3];
            wgm_reg <= wdata_i[a8tc_pkg::A8TC_WGM_LSB +: 2];
            com_reg <= wdata_i[a8tc_pkg::A8TC_COM_LSB +: 2];
         end
         if (wr_async) begin
            aso_reg <= wdata_i[a8tc_pkg::A8TC_ASO_BIT];
         end
         if (wr_mask) begin
            ovf_mask_reg <= wdata_i[a8tc_pkg::A8TC_OVF_BIT];
            cmp_mask_reg <= wdata_i[a8tc_pkg::A8TC_CMP_BIT];
         end
      end
   end

   // ****************************************
   // Counter, direction and match blocking
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_value_reg <= a8tc_pkg::A8TC_RST_BYTE;
         dir_reg <= a8tc_pkg::A8TC_DIR_UP;
         block_reg <= 1'b0;
      end else begin
         if (wr_count) begin
            count_value_reg <= wdata_i;
         end else if (tick) begin
            count_value_reg <= count_value_next;
         end
         if (wgm_reg != a8tc_pkg::A8TC_WGM_PHASE) begin
            dir_reg <= a8tc_pkg::A8TC_DIR_UP;
         end else if (tick && !wr_count) begin
            dir_reg <= dir_next;
         end
         if (wr_count) begin
            block_reg <= 1'b1;
         end else if (tick) begin
            block_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Compare registers and output
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         compare_value_reg <= a8tc_pkg::A8TC_RST_BYTE;
         compare_buffer_reg <= a8tc_pkg::A8TC_RST_BYTE;
         out_reg <= 1'b0;
      end else begin
         compare_value_reg <= compare_value_next;
         if (wr_compare) begin
            compare_buffer_reg <= wdata_i;
         end
         out_reg <= out_next;
      end
   end

   // ****************************************
   // Flags, set wins over clear
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovf_flag_reg <= 1'b0;
         cmp_flag_reg <= 1'b0;
      end else begin
         if (tick && !wr_count && ovf_event) begin
            ovf_flag_reg <= 1'b1;
         end else if (ovf_irq_ack_i || (wr_flag && wdata_i[a8tc_pkg::A8TC_OVF_BIT])) begin
            ovf_flag_reg <= 1'b0;
         end
         if (tick_match) begin
            cmp_flag_reg <= 1'b1;
         end else if (cmp_irq_ack_i || (wr_flag && wdata_i[a8tc_pkg::A8TC_CMP_BIT])) begin
            cmp_flag_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 8'h00;
         ovf_irq_o <= 1'b0;
         cmp_irq_o <= 1'b0;
         compare_output_o <= 1'b0;
         crystal_pin_out_o <= 1'b0;
      end else begin
         rdata_o <= rd_i ? rd_mux : 8'h00;
         ovf_irq_o <= ovf_flag_reg && ovf_mask_reg;
         cmp_irq_o <= cmp_flag_reg && cmp_mask_reg;
         compare_output_o <= out_reg;
         crystal_pin_out_o <= aso_reg && !osc_sync_reg;
      end
   end

endmodule
`default_nettype wire

// ==== a8tc_timer_chk.sv ====
// Port checker of the 8-bit timer with compare channel
`timescale 1ns/1ns
`default_nettype none
module a8tc_timer_chk (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic crystal_pin_in_i,
   input wire logic crystal_pin_out_o,
   input wire logic ovf_irq_ack_i,
   input wire logic cmp_irq_ack_i,
   input wire logic ovf_irq_o,
   input wire logic cmp_irq_o,
   input wire logic compare_output_o
);
   // ****************
   // Shadow of written control bits
   // ****************
   logic [2:0] cs_reg;
   logic [1:0] mode_reg;
   logic [1:0] com_reg;
   logic [1:0] msk_reg;
   logic aso_reg;
   wire ctl_wr = wr_i && addr_i == a8tc_pkg::A8TC_OFS_CTRL;
   wire msk_wr = wr_i && addr_i == a8tc_pkg::A8TC_OFS_MASK;
   wire aso_wr = wr_i && addr_i == a8tc_pkg::A8TC_OFS_ASYNC;
   wire stopped = cs_reg == 3'h0;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_reg <= 3'h0;
         mode_reg <= 2'h0;
         com_reg <= 2'h0;
         msk_reg <= 2'h0;
         aso_reg <= 1'b0;
      end else begin
         if (ctl_wr) begin
            cs_reg <= wdata_i[2:0];
            mode_reg <= wdata_i[4:3];
            com_reg <= wdata_i[6:5];
         end
         if (msk_wr) begin
            msk_reg <= wdata_i[1:0];
         end
         if (aso_wr) begin
            aso_reg <= wdata_i[3];
         end
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence s_cnt_wr;
      wr_i && addr_i == a8tc_pkg::A8TC_OFS_COUNT && stopped;
   endsequence
   sequence s_cnt_rd;
      rd_i && addr_i == a8tc_pkg::A8TC_OFS_COUNT;
   endsequence
   sequence s_flg_wr;
      wr_i && addr_i == a8tc_pkg::A8TC_OFS_FLAG && stopped;
   endsequence
   sequence s_flg_rd;
      rd_i && addr_i == a8tc_pkg::A8TC_OFS_FLAG;
   endsequence
   sequence s_force;
      ctl_wr && wdata_i[7] && !wdata_i[3] && !mode_reg[0] && com_reg[1] && stopped;
   endsequence
   property p_rd_idle;
      !rd_i |=> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_unmapped;
      rd_i && addr_i > 3'h5 |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_cnt_keep;
      s_cnt_wr ##1 s_cnt_rd |=> rdata_o == $past(wdata_i, 2);
   endproperty
   a_cnt_keep: assert property (p_cnt_keep) else $error("count lost");
   property p_w1c;
      s_flg_wr ##1 s_flg_rd |=> (rdata_o & $past(wdata_i, 2)) == 8'h00;
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared by one");
   property p_ack_clr;
      cmp_irq_ack_i && stopped |=> ##1 !cmp_irq_o;
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("compare irq after service");
   property p_cmp_mask;
      !msk_reg[1] |=> !cmp_irq_o;
   endproperty
   a_cmp_mask: assert property (p_cmp_mask) else $error("masked compare irq");
   property p_ovf_mask;
      !msk_reg[0] |=> !ovf_irq_o;
   endproperty
   a_ovf_mask: assert property (p_ovf_mask) else $error("masked overflow irq");
   property p_xtal_off;
      !aso_reg |=> !crystal_pin_out_o;
   endproperty
   a_xtal_off: assert property (p_xtal_off) else $error("crystal out driven");
   property p_force;
      s_force |=> ##1 compare_output_o == ($past(com_reg, 2) == 2'h3);
   endproperty
   a_force: assert property (p_force) else $error("forced output wrong");
endmodule
bind a8tc_timer a8tc_timer_chk chk (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .crystal_pin_in_i(crystal_pin_in_i),
   .crystal_pin_out_o(crystal_pin_out_o), .ovf_irq_ack_i(ovf_irq_ack_i),
   .cmp_irq_ack_i(cmp_irq_ack_i), .ovf_irq_o(ovf_irq_o), .cmp_irq_o(cmp_irq_o),
   .compare_output_o(compare_output_o)
);
`default_nettype wire

// ==== a8tc_timer_test.sv ====
// Self-checking bench of the 8-bit timer with compare channel
`timescale 1ns/1ns
`default_nettype none
module a8tc_timer_test;
   localparam logic [2:0] R_CTL = a8tc_pkg::A8TC_OFS_CTRL;
   localparam logic [2:0] R_CNT = a8tc_pkg::A8TC_OFS_COUNT;
   localparam logic [2:0] R_CMP = a8tc_pkg::A8TC_OFS_COMPARE;
   localparam logic [2:0] R_FLG = a8tc_pkg::A8TC_OFS_FLAG;
   localparam logic [2:0] R_MSK = a8tc_pkg::A8TC_OFS_MASK;
   localparam logic [2:0] R_ASY = a8tc_pkg::A8TC_OFS_ASYNC;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic crystal_pin_in_i = 1'b0;
   logic ovf_irq_ack_i = 1'b0;
   logic cmp_irq_ack_i = 1'b0;
   logic [7:0] rdata_o;
   logic crystal_pin_out_o;
   logic ovf_irq_o;
   logic cmp_irq_o;
   logic compare_output_o;
   logic [7:0] force_ctl [3] = '{8'h60, 8'h40, 8'h20};
   logic force_out [3] = '{1'b1, 1'b0, 1'b1};
   int errors = 0;
   int n_checks = 0;
   a8tc_timer uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .crystal_pin_in_i(crystal_pin_in_i),
      .crystal_pin_out_o(crystal_pin_out_o), .ovf_irq_ack_i(ovf_irq_ack_i),
      .cmp_irq_ack_i(cmp_irq_ack_i), .ovf_irq_o(ovf_irq_o), .cmp_irq_o(cmp_irq_o),
      .compare_output_o(compare_output_o)
   );
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // ****************
   // Bus and compare tasks
   // ****************
   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk1(input string nm, input logic exp, input logic got);
      chk8(nm, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk8(nm, exp, rdata_o);
      @(posedge clk_i);
   endtask
   task automatic look(input int k, input logic exp, input string nm);
      idle(0);
      #1;
      chk1(nm, exp, k == 0 ? compare_output_o : (k == 1 ? ovf_irq_o :
         (k == 2 ? cmp_irq_o : crystal_pin_out_o)));
      @(posedge clk_i);
   endtask
   task automatic run(input logic [7:0] on, input logic [7:0] off, input int n);
      wr(R_CTL, on);
      idle(n - 1);
      wr(R_CTL, off);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      #20000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), 8'h00, "reset read");
      end
      look(0, 1'b0, "reset output");
      look(3, 1'b0, "reset crystal drive");
      done("reset");
      wr(R_CNT, 8'h5a);
      rd(R_CNT, 8'h5a, "stopped count");
      wr(R_CTL, 8'h01);
      wr(R_CNT, 8'h10);
      rd(R_CNT, 8'h10, "count write wins");
      wr(R_CTL, 8'h00);
      done("count access");
      wr(R_MSK, 8'h03);
      wr(R_CNT, 8'hfe);
      run(8'h01, 8'h00, 2);
      rd(R_CNT, 8'h00, "count after wrap");
      rd(R_FLG, 8'h01, "overflow flag");
      look(1, 1'b1, "overflow irq");
      wr(R_FLG, 8'h01);
      rd(R_FLG, 8'h00, "flag write one");
      done("overflow");
      wr(R_CMP, 8'h20);
      wr(R_CNT, 8'h20);
      run(8'h01, 8'h00, 2);
      rd(R_FLG, 8'h00, "blocked match");
      wr(R_CNT, 8'h1f);
      run(8'h01, 8'h00, 2);
      rd(R_CNT, 8'h21, "count after match");
      rd(R_FLG, 8'h02, "compare flag");
      look(2, 1'b1, "compare irq");
      cmp_irq_ack_i <= 1'b1;
      idle(1);
      cmp_irq_ack_i <= 1'b0;
      idle(1);
      look(2, 1'b0, "compare irq serviced");
      done("compare");
      wr(R_CMP, 8'h03);
      wr(R_CNT, 8'h00);
      run(8'h11, 8'h10, 5);
      rd(R_CNT, 8'h01, "clear on match count");
      rd(R_CMP, 8'h03, "direct compare");
      done("clear on match");
      wr(R_FLG, 8'h03);
      for (int i = 0; i < 3; i++) begin
         wr(R_CTL, force_ctl[i]);
         wr(R_CTL, force_ctl[i] | 8'h80);
         idle(1);
         look(0, force_out[i], "forced output");
      end
      rd(R_FLG, 8'h00, "flags after force");
      rd(R_CNT, 8'h01, "count after force");
      done("force");
      wr(R_CTL, 8'h58);
      idle(1);
      look(0, 1'b1, "output after mode change");
      wr(R_FLG, 8'h03);
      wr(R_CMP, 8'h80);
      rd(R_CMP, 8'h80, "compare buffer");
      wr(R_CNT, 8'h02);
      run(8'h59, 8'h58, 3);
      rd(R_FLG, 8'h02, "match on old compare");
      look(0, 1'b0, "output cleared on match");
      wr(R_CNT, 8'hfe);
      run(8'h59, 8'h58, 3);
      look(0, 1'b1, "output set at max");
      rd(R_CNT, 8'h01, "count after restart");
      wr(R_CTL, 8'h00);
      rd(R_CMP, 8'h80, "compare after update");
      rd(R_FLG, 8'h03, "flags in fast mode");
      ovf_irq_ack_i <= 1'b1;
      idle(1);
      ovf_irq_ack_i <= 1'b0;
      rd(R_FLG, 8'h02, "overflow serviced");
      done("fast pwm");
      wr(R_FLG, 8'h03);
      wr(R_CTL, 8'h08);
      wr(R_CMP, 8'h40);
      wr(R_CNT, 8'hfd);
      run(8'h09, 8'h08, 4);
      rd(R_CNT, 8'hfd, "count after top");
      wr(R_CNT, 8'h01);
      run(8'h09, 8'h08, 3);
      rd(R_CNT, 8'h02, "count after bottom");
      rd(R_FLG, 8'h01, "overflow at bottom");
      wr(R_CTL, 8'h00);
      rd(R_CMP, 8'h40, "compare at top");
      wr(R_CNT, 8'h00);
      run(8'h02, 8'h00, 16);
      rd(R_CNT, 8'h02, "divided ticks");
      done("phase pwm");
      wr(R_ASY, 8'h08);
      wr(R_CNT, 8'h00);
      wr(R_CTL, 8'h01);
      repeat (4) begin
         crystal_pin_in_i <= 1'b1;
         idle(3);
         crystal_pin_in_i <= 1'b0;
         idle(3);
      end
      idle(4);
      look(3, 1'b1, "crystal drive");
      wr(R_CTL, 8'h00);
      rd(R_CNT, 8'h04, "crystal ticks");
      wr(R_ASY, 8'h00);
      done("crystal");
      report_and_stop();
   end
endmodule
`default_nettype wire
